// file: common/sarsc_pkg.sv
// package: widths, timing and encoding constants for the short-cycle sequencer
package sarsc_pkg;
	localparam int RES_BITS = 12;
	localparam int CLK_PERIOD_NS = 40;
	localparam int STATUS_DELAY_NS = 40;
	// least time, rounded up, at least one cycle
	localparam int STATUS_DELAY_CYC = ((STATUS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1
		? 1 : ((STATUS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int FULL_CLOCK_CYCLES = 13;
	localparam int BIT_IDX_W = 4;
	localparam logic [BIT_IDX_W-1:0] BIT_IDX_MSB = 4'hB;
	localparam logic [BIT_IDX_W-1:0] BIT_IDX_ZERO = 4'h0;
	localparam logic [RES_BITS-1:0] SAR_ZERO = 12'h000;
	localparam logic [RES_BITS-1:0] SAR_ONES = 12'hFFF;
	localparam logic [RES_BITS-1:0] SAR_MSB_ONLY = 12'h800;
	// output code selection
	localparam logic [1:0] CODE_PLAIN = 2'h0;
	localparam logic [1:0] CODE_OFFSET = 2'h1;
	localparam logic [1:0] CODE_SIGNED = 2'h2;
	typedef enum logic [1:0] {SARSC_IDLE, SARSC_TRIAL, SARSC_HOLD} sarsc_state_e;
endpackage

// file: common/sarsc_res_if.sv
// interface: result word handed from the register core to the output stage
`timescale 1ns/1ps
interface sarsc_res_if;
	logic [11:0] word;
	logic load;
	modport core (output word, output load);
	modport outp (input word, input load);
endinterface

// file: design/sarsc_out_stage.sv
// output storage stage: negative-true parallel result and inverted msb
`timescale 1ns/1ps
module sarsc_out_stage
	import sarsc_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	sarsc_res_if.outp res,
	output logic [RES_BITS-1:0] dataN,
	output logic msbInv
);
	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (!resetn) begin
			dataN <= SAR_ONES;
			msbInv <= 1'b0;
		end else if (res.load) begin
			dataN <= ~res.word;
			msbInv <= res.word[RES_BITS-1];
		end
	end

	a_msb_inverse: assert property (@(posedge clk) disable iff (!resetn)
		msbInv == ~dataN[RES_BITS-1]) else $error("msb inverse mismatch");
	a_load_updates: assert property (@(posedge clk) disable iff (!resetn)
		res.load |=> dataN == ~$past(res.word)) else $error("output not loaded");
endmodule // sarsc_out_stage

// file: design/sar_short_cycle_sequencer.sv
// top: successive-approximation sequencer with short-cycle termination
// Contract
// - resolution select ends the bit sequence early after any chosen MSB count.
// - select tied to bit-11 output stops after bit 10, busy clears 40 ns later.
// - twelve, ten and eight bit lengths are supported.
// - result is complemented binary only; the output code selection constants are unused.
// - an extra output carries the inverted result MSB.
// - full scale all zeros, mid scale 0111.., negative scale 11..11.
// - start sets busy and runs the internal clock 13 cycles at full length.
// - one bit trialled per cycle MSB first, kept by comparator state.
// - busy clears 40 ns after final decision; data valid at its fall.
// - result held in negative-true registers updated on clock edges.
`timescale 1ns/1ps
module sar_short_cycle_sequencer
	import sarsc_pkg::*;
#(
	parameter int WIDTH = RES_BITS
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic convStart,
	input wire logic compKeep,
	input wire logic shortCycle,
	output logic busy,
	output logic gatedClk,
	output logic [RES_BITS-1:0] dacBits,
	output logic [RES_BITS-1:0] dataN,
	output logic msbInv,
	output logic bit11Out
);
	if (WIDTH != RES_BITS) begin : g_width_check
		$error("WIDTH must equal RES_BITS");
	end

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	// comparator and select come from logic on this clock (own bit outputs or a strap):
	// a synchroniser there would outlast the one-cycle bit period
	logic [2:0] startSync;
	logic startLvl;
	logic startPrev;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			startSync <= 3'h0;
		end else begin
			startSync <= {startSync[1:0], convStart};
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			startLvl <= 1'b0;
		end else if (startSync[1] == startSync[2]) begin
			startLvl <= startSync[2];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			startPrev <= 1'b0;
		end else begin
			startPrev <= startLvl;
		end
	end

	// conversion begins on the trailing edge of start
	logic startFall;
	assign startFall = startPrev && !startLvl;

	////////////////////////////////////////////////////////////////////////////
	// sequencer
	sarsc_state_e state;
	logic [BIT_IDX_W-1:0] bitIdx;
	logic [RES_BITS-1:0] sar;
	logic [3:0] delayCnt;
	logic [4:0] clkCycles;
	logic lastBit;
	logic cutNow;
	logic seqEnd;
	logic [RES_BITS-1:0] next_sar;

	// select low at a bit boundary: the decision just made was the last one
	assign cutNow = (state == SARSC_TRIAL) && !shortCycle;
	assign lastBit = (bitIdx == BIT_IDX_ZERO);
	assign seqEnd = (state == SARSC_HOLD && delayCnt == 4'(STATUS_DELAY_CYC - 1)) ||
		(cutNow && STATUS_DELAY_CYC == 1);

	function automatic logic [RES_BITS-1:0] bitMask(input logic [BIT_IDX_W-1:0] idx);
		bitMask = RES_BITS'(1) << idx;
	endfunction

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state <= SARSC_IDLE;
			bitIdx <= BIT_IDX_MSB;
			delayCnt <= 4'h0;
		end else if (startFall) begin
			state <= SARSC_TRIAL;
			bitIdx <= BIT_IDX_MSB;
			delayCnt <= 4'h0;
		end else begin
			unique case (state)
				SARSC_IDLE: begin
					state <= SARSC_IDLE;
				end
				SARSC_TRIAL: begin
					if (seqEnd) begin
						state <= SARSC_IDLE;
					end else if (cutNow) begin
						state <= SARSC_HOLD;
						delayCnt <= 4'h1;
					end else if (lastBit) begin
						state <= SARSC_HOLD;
						delayCnt <= 4'h0;
					end else begin
						bitIdx <= bitIdx - 4'h1;
					end
				end
				SARSC_HOLD: begin
					if (seqEnd) begin
						state <= SARSC_IDLE;
					end else begin
						delayCnt <= delayCnt + 4'h1;
					end
				end
			endcase
		end
	end

	// sar: bit under trial set, kept or rejected at end of its period
	always_comb begin
		next_sar = sar;
		if (startFall) begin
			next_sar = SAR_MSB_ONLY;
		end else if (state == SARSC_TRIAL && !cutNow) begin
			if (!compKeep) begin
				next_sar = next_sar & ~bitMask(bitIdx);
			end
			if (!lastBit) begin
				next_sar = next_sar | bitMask(bitIdx - 4'h1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sar <= SAR_ZERO;
		end else begin
			sar <= next_sar;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			busy <= 1'b0;
		end else begin
			busy <= startFall || (state != SARSC_IDLE && !seqEnd);
		end
	end

	// gated clock is held high through every bit period while converting
	always_ff @(posedge clk) begin
		if (!resetn) begin
			gatedClk <= 1'b0;
			clkCycles <= 5'h0;
		end else begin
			gatedClk <= startFall || (state == SARSC_TRIAL && !cutNow);
			if (startFall) begin
				clkCycles <= 5'h0;
			end else if (gatedClk && clkCycles != 5'h1F) begin
				clkCycles <= clkCycles + 5'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			dacBits <= SAR_ZERO;
			bit11Out <= 1'b1;
		end else begin
			dacBits <= next_sar;
			bit11Out <= ~next_sar[1];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output registers
	sarsc_res_if resBus ();
	// outputs follow each decision, kept or rejected, so they are settled before busy falls
	assign resBus.word = next_sar;
	assign resBus.load = (state == SARSC_TRIAL) && !cutNow;

	sarsc_out_stage uOut (
		.clk(clk),
		.resetn(resetn),
		.res(resBus),
		.dataN(dataN),
		.msbInv(msbInv)
	);

	////////////////////////////////////////////////////////////////////////////
	a_start_sets_busy: assert property (@(posedge clk) disable iff (!resetn)
		startFall |=> busy) else $error("busy not set by start");
	a_full_length: assert property (@(posedge clk) disable iff (!resetn)
		(startFall ##1 (shortCycle && !startFall)[*8]) |-> state != SARSC_IDLE)
		else $error("conversion ended early");
	a_short_stop: assert property (@(posedge clk) disable iff (!resetn)
		(state == SARSC_TRIAL && !shortCycle && !startFall) |=> (state != SARSC_TRIAL && !busy))
		else $error("short cycle ignored");
	a_busy_delay: assert property (@(posedge clk) disable iff (!resetn)
		(state == SARSC_TRIAL && lastBit && shortCycle && !startFall)
		|=> busy ##1 (!busy || $past(startFall)))
		else $error("busy delay wrong");
	a_data_valid: assert property (@(posedge clk) disable iff (!resetn)
		$fell(busy) |-> dataN == ~sar) else $error("data not valid at busy fall");
	a_data_settled: assert property (@(posedge clk) disable iff (!resetn)
		$fell(busy) |-> $stable(dataN)) else $error("data moved at busy fall");
	a_msb_first: assert property (@(posedge clk) disable iff (!resetn)
		startFall |=> sar == SAR_MSB_ONLY) else $error("msb not trialled first");
	a_clock_gated: assert property (@(posedge clk) disable iff (!resetn)
		!busy |-> !gatedClk) else $error("clock runs while idle");
	a_cycle_bound: assert property (@(posedge clk) disable iff (!resetn)
		clkCycles <= 5'(FULL_CLOCK_CYCLES)) else $error("too many clock cycles");
endmodule // sar_short_cycle_sequencer

// file: dv/sarsc_comp_model.sv
// comparator and feedback dac model facing the sequencer
`timescale 1ns/1ps
module sarsc_comp_model
	import sarsc_pkg::*;
(
	input wire logic [RES_BITS-1:0] dacBits,
	input wire logic [RES_BITS-1:0] target,
	output logic compKeep
);
	// keep the trial bit while the dac stays at or below the input
	assign compKeep = (dacBits <= target);
endmodule // sarsc_comp_model

// file: dv/sar_short_cycle_sequencer_test.sv
// testbench: conversions at three lengths and output code end points
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; $display("ERROR %0t: got %h want %h", $time, a, b); end end
module sar_short_cycle_sequencer_test;
	import sarsc_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic convStart = 1'b0;
	logic compKeep, shortCycle, busy, gatedClk, msbInv, bit11Out;
	logic [RES_BITS-1:0] dacBits, dataN, last;
	logic [RES_BITS-1:0] target = 12'h000;
	logic [1:0] mode = 2'h0;
	int failures = 0;
	int checked = 0;
	int cycles = 0;
	always #20 clk = ~clk;
	// select tied high, to the bit-11 pin, or to the bit-9 line
	always_comb shortCycle = (mode == 2'h0) ? 1'b1 : (mode == 2'h1) ? bit11Out : ~dacBits[3];
	sar_short_cycle_sequencer sar_short_cycle_sequencer_i (.clk(clk), .resetn(resetn),
		.convStart(convStart), .compKeep(compKeep), .shortCycle(shortCycle), .busy(busy),
		.gatedClk(gatedClk), .dacBits(dacBits), .dataN(dataN), .msbInv(msbInv),
		.bit11Out(bit11Out));
	sarsc_comp_model sarsc_comp_model_i (.dacBits(dacBits), .target(target), .compKeep(compKeep));
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			failures++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic convert(input logic [11:0] t, input logic [1:0] m, output int n);
		int w;
		@(negedge clk);
		target = t;
		mode = m;
		convStart = 1'b1;
		repeat (3) @(negedge clk);
		convStart = 1'b0;
		w = 0;
		while (busy !== 1'b1 && w < 20) begin
			@(negedge clk);
			w++;
		end
		n = 0;
		while (busy === 1'b1 && n < 40) begin
			last = dataN;
			n++;
			@(negedge clk);
		end
		`CHK(gatedClk, 1'b0)
		`CHK(dataN, last)
	endtask
	task automatic codes();
		logic [11:0] tab [5] = '{12'hFFF, 12'h800, 12'h001, 12'h000, 12'hA5C};
		int n;
		foreach (tab[i]) begin
			convert(tab[i], 2'h0, n);
			`CHK(n, FULL_CLOCK_CYCLES)
			`CHK(dataN, ~tab[i])
			`CHK(msbInv, tab[i][11])
		end
	endtask
	task automatic lengths();
		int n;
		convert(12'h5A7, 2'h1, n);
		`CHK(n, FULL_CLOCK_CYCLES - 2)
		`CHK(dataN[11:2], ~target[11:2])
		convert(12'h3C9, 2'h2, n);
		`CHK(n, FULL_CLOCK_CYCLES - 4)
		`CHK(dataN[11:4], ~target[11:4])
		convert(12'h3C9, 2'h0, n);
		`CHK(dataN, 12'hC36)
	endtask
	task automatic end_of_test();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(negedge clk);
		resetn = 1'b1;
		@(negedge clk);
		`CHK({busy, gatedClk, msbInv, bit11Out, dataN}, {4'h1, SAR_ONES})
		codes();
		lengths();
		end_of_test();
	end
endmodule // sar_short_cycle_sequencer_test
